// ---- dmmu_fault_params.svh ----
`ifndef DMMU_FAULT_PARAMS_SVH
`define DMMU_FAULT_PARAMS_SVH

// Register byte offsets
`define OFF_FAULT_STATUS 12'h000
`define OFF_FAULT_ADDR 12'h004
`define OFF_TLB_INFO 12'h008
`define OFF_IRQ_STATUS 12'h00c
`define OFF_IRQ_MASK 12'h010

// Fault status field positions
`define FS_FV 0
`define FS_OW 1
`define FS_W 2
`define FS_PR 3
`define FS_CT_LO 4
`define FS_E 6
`define FS_FT_LO 7
`define FS_TM 15
`define FS_SEL_LO 16
`define FS_NF 24
`define FS_UE 25
`define FS_BUS_ERROR_FLAG 26
`define FS_BUS_TIMEOUT_FLAG 27
`define FS_MH 28
`define FS_NC 29

// Fault kind bit positions
`define FK_PRIV 0
`define FK_NF_SIDE 1
`define FK_NOCACHE 2
`define FK_BAD_ACCESS 3
`define FK_NFO 4
`define FK_RSVD_MASK 7'h60

// Tlb info field positions
`define TI_IDX_LO 0
`define TI_NUM_LO 16

// Interrupt status bits
`define IRQ_MISS 0
`define IRQ_FAULT 1
`define IRQ_OVER 2

// Context code for non-translating or invalid selector
`define CTX_NONTRANS 2'h3

// Reset values
`define RST_WORD 32'h0
`define RST_FK 7'h00

`endif

// ---- dmmu_fault_pkg.sv ----
package dmmu_fault_pkg;

  typedef enum logic [3:0] {
    EV_MISS = 4'b0000,
    EV_ACC_EXC = 4'b0001,
    EV_PROT = 4'b0010,
    EV_PA_WP = 4'b0011,
    EV_VA_WP = 4'b0100,
    EV_PRIV = 4'b0101,
    EV_MISALIGN = 4'b0110,
    EV_ACC_ERR = 4'b0111,
    EV_ACROSS = 4'b1000
  } evt_kind_t;

  typedef enum logic [1:0] {
    REC_EMPTY = 2'b00,
    REC_MISS = 2'b01,
    REC_FAULT = 2'b10,
    REC_FAULT_MISS = 2'b11
  } rec_state_t;

  typedef struct packed {
    evt_kind_t kind;
    logic priv_from_mem;
    logic store;
    logic supv;
    logic no_fault_load;
    logic [7:0] space_selector;
    logic sel_translating;
    logic sel_invalid;
    logic [1:0] ctx_sel;
    logic bad_va;
    logic bad_rw;
    logic invalid_len;
    logic page_priv;
    logic as_if_user;
    logic page_side_eff;
    logic page_cacheable;
    logic atomic_or_simd;
    logic no_fault_only_attr;
    logic [31:0] vaddr;
  } access_evt_t;

  typedef struct packed {
    logic uncorrectable;
    logic bus_error;
    logic bus_timeout;
    logic multi_hit;
    logic noncache;
    logic side_effect;
    logic [1:0] tlb_num;
    logic [7:0] tlb_index;
  } err_info_t;

  typedef struct packed {
    logic counted;
    logic is_miss;
    logic sets_kind;
    logic sets_err;
    logic [1:0] ctx_code;
  } evt_class_t;

endpackage

// ---- fault_kind_encode.sv ----
`timescale 1ns/1ps
`include "dmmu_fault_params.svh"

module fault_kind_encode
  import dmmu_fault_pkg::*;
(
  input wire access_evt_t evt_in,
  output logic [6:0] fault_kind_out
);

  logic bad_access;

  // Selector check precedes lookup, so page bits are masked
  assign bad_access = evt_in.sel_invalid | evt_in.bad_va | evt_in.bad_rw;

  always_comb begin
    fault_kind_out = `RST_FK;
    if (bad_access) begin
      fault_kind_out[`FK_BAD_ACCESS] = 1'b1;
    end else begin
      // All coinciding conditions are reported together
      fault_kind_out[`FK_PRIV] = evt_in.page_priv & (~evt_in.supv | evt_in.as_if_user);
      fault_kind_out[`FK_NF_SIDE] = evt_in.no_fault_load & evt_in.page_side_eff;
      fault_kind_out[`FK_NOCACHE] = evt_in.atomic_or_simd & ~evt_in.page_cacheable;
      fault_kind_out[`FK_NFO] = ~evt_in.no_fault_load & evt_in.no_fault_only_attr;
    end
    fault_kind_out = fault_kind_out & ~`FK_RSVD_MASK;
  end

endmodule // fault_kind_encode

// ---- event_classify.sv ----
`timescale 1ns/1ps
`include "dmmu_fault_params.svh"

module event_classify
  import dmmu_fault_pkg::*;
(
  input wire logic valid_in,
  input wire access_evt_t evt_in,
  output evt_class_t class_out
);

  always_comb begin
    class_out = '0;
    class_out.counted = valid_in;
    if (evt_in.kind == EV_PRIV && !evt_in.priv_from_mem) begin
      class_out.counted = 1'b0;
    end
    // Invalid length is a misalignment, never an access exception
    if (evt_in.invalid_len) begin
      class_out.is_miss = 1'b0;
    end else if (evt_in.kind == EV_MISS) begin
      class_out.is_miss = 1'b1;
    end else if (evt_in.kind == EV_ACC_EXC) begin
      class_out.sets_kind = 1'b1;
    end else if (evt_in.kind == EV_ACC_ERR) begin
      class_out.sets_err = 1'b1;
    end
    if (evt_in.sel_invalid || !evt_in.sel_translating) begin
      class_out.ctx_code = `CTX_NONTRANS;
    end else begin
      class_out.ctx_code = evt_in.ctx_sel;
    end
  end

endmodule // event_classify

// ---- data_mmu_fault_status.sv ----
`timescale 1ns/1ps
`include "dmmu_fault_params.svh"

module data_mmu_fault_status
  import dmmu_fault_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic evt_valid_in,
  input wire access_evt_t evt_in,
  input wire err_info_t err_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic irq_out
);

  evt_class_t cls;
  logic [6:0] kind_now;
  logic ev;
  logic ev_miss;
  logic ev_fault;
  rec_state_t rec;

  logic fault_valid_r;
  logic second_fault_flag_r;
  logic tlb_miss_flag_r;
  logic store_r;
  logic supv_mode_flag_r;
  logic no_fault_load_flag_r;
  logic [1:0] context_id_sel_r;
  logic [6:0] fault_kind_r;
  logic [7:0] space_selector_r;
  logic uncorrectable_flag_r;
  logic bus_error_flag_r;
  logic bus_timeout_flag_r;
  logic multi_hit_flag_r;
  logic noncache_r;
  logic side_eff_r;
  logic [31:0] data_fault_addr_r;
  logic [1:0] tlb_num_r;
  logic [7:0] tlb_index_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [31:0] prdata_r;

  logic fv_nxt;
  logic ow_nxt;
  logic tm_nxt;
  logic upd_ctx;
  logic upd_sel;
  logic upd_kind;
  logic upd_err;
  logic [6:0] kind_nxt;

  logic wr;
  logic rd_setup;
  logic hit_status;
  logic hit_addr;
  logic hit_tlb;
  logic hit_istat;
  logic hit_imask;
  logic hit_any;
  logic [31:0] status_word;
  logic [31:0] tlb_word;
  logic [31:0] rd_word;
  logic [2:0] irq_set;
  logic err_cause;

  fault_kind_encode u_kind (
    .evt_in(evt_in),
    .fault_kind_out(kind_now)
  );

  event_classify u_class (
    .valid_in(evt_valid_in),
    .evt_in(evt_in),
    .class_out(cls)
  );

  assign ev = cls.counted;
  assign ev_miss = ev & cls.is_miss;
  assign ev_fault = ev & ~cls.is_miss;
  assign rec = rec_state_t'({fault_valid_r, tlb_miss_flag_r});
  assign err_cause = err_in.uncorrectable | err_in.bus_error | err_in.bus_timeout;

  // Update policy per recorded state and event class
  always_comb begin
    fv_nxt = fault_valid_r;
    ow_nxt = second_fault_flag_r;
    tm_nxt = tlb_miss_flag_r;
    upd_ctx = 1'b0;
    upd_sel = 1'b0;
    upd_kind = 1'b0;
    upd_err = 1'b0;
    kind_nxt = fault_kind_r;
    if (ev_miss) begin
      case (rec)
        REC_EMPTY: begin
          fv_nxt = 1'b0;
          ow_nxt = 1'b0;
          tm_nxt = 1'b1;
          upd_ctx = 1'b1;
          upd_sel = 1'b1;
        end
        REC_MISS: begin
          tm_nxt = 1'b1;
          upd_ctx = 1'b1;
        end
        default: begin
          fv_nxt = 1'b1;
          tm_nxt = 1'b1;
        end
      endcase
    end else if (ev_fault) begin
      fv_nxt = 1'b1;
      upd_ctx = 1'b1;
      upd_sel = 1'b1;
      case (rec)
        REC_EMPTY: begin
          ow_nxt = 1'b0;
          tm_nxt = 1'b0;
          upd_kind = 1'b1;
          upd_err = 1'b1;
          kind_nxt = cls.sets_kind ? kind_now : `RST_FK;
        end
        REC_FAULT, REC_FAULT_MISS: begin
          ow_nxt = 1'b1;
          upd_kind = cls.sets_kind;
          upd_err = cls.sets_err;
          kind_nxt = kind_now;
        end
        default: begin
          upd_kind = cls.sets_kind;
          upd_err = cls.sets_err;
          kind_nxt = kind_now;
        end
      endcase
    end
  end

  assign wr = psel_in & penable_in & pwrite_in;
  assign rd_setup = psel_in & ~penable_in & ~pwrite_in;
  assign hit_status = (paddr_in == `OFF_FAULT_STATUS);
  assign hit_addr = (paddr_in == `OFF_FAULT_ADDR);
  assign hit_tlb = (paddr_in == `OFF_TLB_INFO);
  assign hit_istat = (paddr_in == `OFF_IRQ_STATUS);
  assign hit_imask = (paddr_in == `OFF_IRQ_MASK);
  assign hit_any = hit_status | hit_addr | hit_tlb | hit_istat | hit_imask;

  // Flags: hardware event wins over a software write
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_valid_r <= 1'b0;
      second_fault_flag_r <= 1'b0;
      tlb_miss_flag_r <= 1'b0;
    end else if (ev) begin
      fault_valid_r <= fv_nxt;
      second_fault_flag_r <= ow_nxt;
      tlb_miss_flag_r <= tm_nxt;
    end else if (wr && hit_status) begin
      fault_valid_r <= pwdata_in[`FS_FV];
      second_fault_flag_r <= pwdata_in[`FS_OW];
      tlb_miss_flag_r <= pwdata_in[`FS_TM];
    end
  end

  // Context related fields
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      store_r <= 1'b0;
      supv_mode_flag_r <= 1'b0;
      no_fault_load_flag_r <= 1'b0;
      context_id_sel_r <= 2'h0;
    end else if (upd_ctx) begin
      store_r <= evt_in.store;
      supv_mode_flag_r <= evt_in.supv;
      no_fault_load_flag_r <= evt_in.no_fault_load;
      context_id_sel_r <= cls.ctx_code;
    end else if (wr && hit_status) begin
      store_r <= pwdata_in[`FS_W];
      supv_mode_flag_r <= pwdata_in[`FS_PR];
      no_fault_load_flag_r <= pwdata_in[`FS_NF];
      context_id_sel_r <= pwdata_in[`FS_CT_LO +: 2];
    end
  end

  // Selector and fault address; a fresh miss leaves the selector unchanged
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      space_selector_r <= 8'h00;
    end else if (upd_sel && ev_fault) begin
      space_selector_r <= evt_in.space_selector;
    end else if (wr && hit_status) begin
      space_selector_r <= pwdata_in[`FS_SEL_LO +: 8];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_fault_addr_r <= `RST_WORD;
    end else if (upd_sel) begin
      data_fault_addr_r <= evt_in.vaddr;
    end else if (wr && hit_addr) begin
      data_fault_addr_r <= pwdata_in;
    end
  end

  // Fault kind
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fault_kind_r <= `RST_FK;
    end else if (upd_kind) begin
      fault_kind_r <= kind_nxt;
    end else if (wr && hit_status) begin
      fault_kind_r <= pwdata_in[`FS_FT_LO +: 7] & ~`FK_RSVD_MASK;
    end
  end

  // Access error fields
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      uncorrectable_flag_r <= 1'b0;
      bus_error_flag_r <= 1'b0;
      bus_timeout_flag_r <= 1'b0;
      multi_hit_flag_r <= 1'b0;
      noncache_r <= 1'b0;
      side_eff_r <= 1'b0;
    end else if (upd_err) begin
      uncorrectable_flag_r <= cls.sets_err & err_in.uncorrectable;
      bus_error_flag_r <= cls.sets_err & err_in.bus_error;
      bus_timeout_flag_r <= cls.sets_err & err_in.bus_timeout;
      multi_hit_flag_r <= cls.sets_err & err_in.multi_hit;
      noncache_r <= cls.sets_err & err_cause & err_in.noncache;
      side_eff_r <= cls.sets_err & err_cause & err_in.side_effect;
    end else if (wr && hit_status) begin
      uncorrectable_flag_r <= pwdata_in[`FS_UE];
      bus_error_flag_r <= pwdata_in[`FS_BUS_ERROR_FLAG];
      bus_timeout_flag_r <= pwdata_in[`FS_BUS_TIMEOUT_FLAG];
      multi_hit_flag_r <= pwdata_in[`FS_MH];
      noncache_r <= pwdata_in[`FS_NC];
      side_eff_r <= pwdata_in[`FS_E];
    end
  end

  // Tlb number and index
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tlb_num_r <= 2'h0;
      tlb_index_r <= 8'h00;
    end else if (upd_err && cls.sets_err && err_in.multi_hit) begin
      tlb_num_r <= err_in.tlb_num;
      tlb_index_r <= err_in.tlb_index;
    end else if (wr && hit_tlb) begin
      tlb_num_r <= pwdata_in[`TI_NUM_LO +: 2];
      tlb_index_r <= pwdata_in[`TI_IDX_LO +: 8];
    end
  end

  // Interrupt status, write one to clear, set wins
  assign irq_set[`IRQ_MISS] = ev_miss;
  assign irq_set[`IRQ_FAULT] = ev_fault;
  assign irq_set[`IRQ_OVER] = ev_fault & fault_valid_r;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_r <= 3'h0;
    end else if (wr && hit_istat) begin
      irq_stat_r <= (irq_stat_r & ~pwdata_in[2:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_r <= 3'h0;
    end else if (wr && hit_imask) begin
      irq_mask_r <= pwdata_in[2:0];
    end
  end

  assign irq_out = |(irq_stat_r & irq_mask_r);

  // Read assembly
  always_comb begin
    status_word = `RST_WORD;
    status_word[`FS_FV] = fault_valid_r;
    status_word[`FS_OW] = second_fault_flag_r;
    status_word[`FS_W] = store_r;
    status_word[`FS_PR] = supv_mode_flag_r;
    status_word[`FS_CT_LO +: 2] = context_id_sel_r;
    status_word[`FS_E] = side_eff_r;
    status_word[`FS_FT_LO +: 7] = fault_kind_r & ~`FK_RSVD_MASK;
    status_word[`FS_TM] = tlb_miss_flag_r;
    status_word[`FS_SEL_LO +: 8] = space_selector_r;
    status_word[`FS_NF] = no_fault_load_flag_r;
    status_word[`FS_UE] = uncorrectable_flag_r;
    status_word[`FS_BUS_ERROR_FLAG] = bus_error_flag_r;
    status_word[`FS_BUS_TIMEOUT_FLAG] = bus_timeout_flag_r;
    status_word[`FS_MH] = multi_hit_flag_r;
    status_word[`FS_NC] = noncache_r;
  end

  always_comb begin
    tlb_word = `RST_WORD;
    tlb_word[`TI_IDX_LO +: 8] = tlb_index_r;
    tlb_word[`TI_NUM_LO +: 2] = tlb_num_r;
  end

  always_comb begin
    rd_word = `RST_WORD;
    if (hit_status) begin
      rd_word = status_word;
    end else if (hit_addr) begin
      rd_word = data_fault_addr_r;
    end else if (hit_tlb) begin
      rd_word = tlb_word;
    end else if (hit_istat) begin
      rd_word = {29'h0, irq_stat_r};
    end else if (hit_imask) begin
      rd_word = {29'h0, irq_mask_r};
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prdata_r <= `RST_WORD;
    end else if (rd_setup) begin
      prdata_r <= rd_word;
    end
  end

  assign prdata_out = prdata_r;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~hit_any;

endmodule // data_mmu_fault_status

// ---- core_lsu_model.sv ----
`timescale 1ns/1ps

module core_lsu_model
  import dmmu_fault_pkg::*;
(
  input wire logic sys_clk_in,
  output logic evt_valid_out,
  output access_evt_t evt_out,
  output err_info_t err_out
);
  initial begin
    evt_valid_out = 1'b0;
    evt_out = '0;
    err_out = '0;
  end

  // Optional stall, one-cycle pulse, then a scrambled bus
  task automatic send(input access_evt_t e, input err_info_t r, input int gap);
    repeat (gap) @(posedge sys_clk_in);
    @(posedge sys_clk_in);
    evt_valid_out <= 1'b1;
    evt_out <= e;
    err_out <= r;
    @(posedge sys_clk_in);
    evt_valid_out <= 1'b0;
    evt_out <= access_evt_t'(~e);
    err_out <= err_info_t'(~r);
  endtask
endmodule // core_lsu_model

// ---- dmmu_fault_checker_sva.sv ----
`timescale 1ns/1ps
`include "dmmu_fault_params.svh"

module dmmu_fault_checker
  import dmmu_fault_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic evt_valid_in,
  input wire access_evt_t evt_in,
  input wire err_info_t err_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic irq_out
);
  logic [2:0] mask_r;
  logic fv_r;
  logic tm_r;
  logic mh_r;
  logic wr;
  logic cnt;
  logic miss;
  logic rd_st;

  assign wr = psel_in & penable_in & pwrite_in;
  assign cnt = evt_valid_in & ((evt_in.kind != EV_PRIV) | evt_in.priv_from_mem);
  assign miss = (evt_in.kind == EV_MISS) & !evt_in.invalid_len;
  assign rd_st = psel_in & !penable_in & !pwrite_in & (paddr_in == `OFF_FAULT_STATUS);

  // Shadow of mask, valid flag, miss flag and multi-hit history
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      mask_r <= 3'h0;
      fv_r <= 1'b0;
      tm_r <= 1'b0;
      mh_r <= 1'b0;
    end else begin
      if (wr & (paddr_in == `OFF_IRQ_MASK)) mask_r <= pwdata_in[2:0];
      if (wr & !cnt & (paddr_in == `OFF_FAULT_STATUS)) fv_r <= pwdata_in[0];
      if (wr & !cnt & (paddr_in == `OFF_FAULT_STATUS)) tm_r <= pwdata_in[15];
      if (wr & (paddr_in == `OFF_TLB_INFO)) mh_r <= 1'b1;
      if (cnt & !miss) fv_r <= 1'b1;
      if (cnt & miss) tm_r <= 1'b1;
      if (cnt & (evt_in.kind == EV_ACC_ERR) & err_in.multi_hit) mh_r <= 1'b1;
    end
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  miss_irq_a:
    assert property (cnt & miss & mask_r[0] & !psel_in |=> irq_out) else $error("miss did not raise irq");
  fault_irq_a:
    assert property (cnt & !miss & mask_r[1] & !psel_in |=> irq_out) else $error("fault did not raise irq");
  over_irq_a:
    assert property (cnt & !miss & fv_r & mask_r[2] & !psel_in |=> irq_out) else $error("no overwrite irq");
  priv_ignored_a:
    assert property (evt_valid_in & (evt_in.kind == EV_PRIV) & !evt_in.priv_from_mem & !irq_out & !psel_in
      |=> !irq_out) else $error("non-memory privileged event counted");
  kind_rsvd_a:
    assert property (rd_st |=> prdata_out[13:12] == 2'b00) else $error("reserved kind bit set");
  read_fv_a:
    assert property (rd_st |=> prdata_out[0] == $past(fv_r)) else $error("valid flag wrong");
  read_tm_a:
    assert property (rd_st |=> prdata_out[15] == $past(tm_r)) else $error("miss flag wrong");
  tlb_quiet_a:
    assert property (psel_in & !penable_in & !pwrite_in & (paddr_in == `OFF_TLB_INFO) & !mh_r |=> prdata_out == 32'h0)
      else $error("tlb info without multi hit");

  cover property (cnt & miss & fv_r);
  cover property (cnt & !miss & fv_r);
  cover property (psel_in & penable_in & pslverr_out);
endmodule // dmmu_fault_checker

bind data_mmu_fault_status dmmu_fault_checker u_dmmu_fault_checker (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
  .evt_valid_in(evt_valid_in), .evt_in(evt_in), .err_in(err_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .irq_out(irq_out));

// ---- data_mmu_fault_status_bench.sv ----
`timescale 1ns/1ps

module data_mmu_fault_status_bench
  import dmmu_fault_pkg::*;
;
  localparam logic [11:0] st = 12'h000;
  localparam logic [11:0] fa = 12'h004;
  localparam logic [11:0] ti = 12'h008;
  localparam logic [11:0] is = 12'h00c;
  localparam logic [11:0] im = 12'h010;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq, evt_valid, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  access_evt_t evt, e;
  err_info_t err, r;
  int fails, n_tests;

  data_mmu_fault_status u_data_mmu_fault_status (.sys_clk_in(sys_clk), .rst_in(rst), .evt_valid_in(evt_valid),
    .evt_in(evt), .err_in(err), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .irq_out(irq));
  core_lsu_model u_core_lsu_model (.sys_clk_in(sys_clk), .evt_valid_out(evt_valid), .evt_out(evt), .err_out(err));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  task automatic test_done();
    if (fails == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      fails++;
      test_done();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic clr();
    wr(st, 32'h0);
    wr(is, 32'h7);
  endtask

  task automatic ev(input err_info_t rr, input int g);
    u_core_lsu_model.send(e, rr, g);
  endtask

  function automatic access_evt_t mk(input evt_kind_t k, input logic [7:0] s, input logic [31:0] va);
    mk = '0;
    mk.kind = k;
    mk.priv_from_mem = 1'b1;
    mk.sel_translating = 1'b1;
    mk.space_selector = s;
    mk.vaddr = va;
  endfunction

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fails = 0;
    n_tests = 0;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    wr(12'h014, 32'hffff_ffff);
    for (int i = 0; i < 6; i++) begin
      rdc(12'(4 * i), 32'h0);
      chk(32'(se), 32'(i == 5));
    end
    wr(im, 32'h7);
    e = mk(EV_MISS, 8'h80, 32'h1234_5678);
    e.store = 1'b1;
    e.supv = 1'b1;
    e.ctx_sel = 2'b01;
    ev('0, 0);
    rdc(st, 32'h0000_801c);
    rdc(fa, 32'h1234_5678);
    rdc(is, 32'h1);
    e = mk(EV_MISS, 8'h81, 32'h1000);
    e.ctx_sel = 2'b10;
    ev('0, 3);
    rdc(st, 32'h0000_8020);
    rdc(fa, 32'h1234_5678);
    e = mk(EV_ACC_EXC, 8'h04, 32'hdead_0000);
    e.bad_va = 1'b1;
    e.supv = 1'b1;
    ev('0, 0);
    rdc(st, 32'h0004_8409);
    rdc(fa, 32'hdead_0000);
    rdc(is, 32'h3);
    e = mk(EV_ACC_ERR, 8'h15, 32'hbeef_0000);
    e.sel_translating = 1'b0;
    e.store = 1'b1;
    e.ctx_sel = 2'b01;
    r = '0;
    r.uncorrectable = 1'b1;
    r.multi_hit = 1'b1;
    r.noncache = 1'b1;
    r.side_effect = 1'b1;
    r.tlb_num = 2'h2;
    r.tlb_index = 8'h5a;
    ev(r, 0);
    rdc(st, 32'h3215_8477);
    rdc(ti, 32'h0002_005a);
    rdc(is, 32'h7);
    e = mk(EV_ACC_ERR, 8'h20, 32'h0);
    r = '0;
    r.noncache = 1'b1;
    r.side_effect = 1'b1;
    ev(r, 0);
    rdc(st, 32'h0020_8403);
    rdc(ti, 32'h0002_005a);
    e = mk(EV_MISS, 8'h99, 32'h7777);
    e.store = 1'b1;
    ev('0, 0);
    rdc(st, 32'h0020_8403);
    rdc(fa, 32'h0);
    e = mk(EV_ACC_EXC, 8'h80, 32'h40);
    e.no_fault_only_attr = 1'b1;
    ev('0, 0);
    rdc(st, 32'h0080_8803);
    wr(im, 32'h0);
    chk(32'(irq), 32'h0);
    wr(im, 32'h7);
    chk(32'(irq), 32'h1);
    clr();
    chk(32'(irq), 32'h0);
    e = mk(EV_PRIV, 8'h80, 32'h8);
    e.priv_from_mem = 1'b0;
    ev('0, 0);
    rdc(st, 32'h0);
    rdc(is, 32'h0);
    e = mk(EV_ACC_EXC, 8'h80, 32'h0);
    e.no_fault_only_attr = 1'b1;
    e.page_priv = 1'b1;
    ev('0, 0);
    rdc(st, 32'h0080_0881);
    clr();
    e.no_fault_load = 1'b1;
    ev('0, 0);
    rdc(st, 32'h0180_0081);
    clr();
    e = mk(EV_ACC_EXC, 8'hff, 32'h0);
    e.sel_invalid = 1'b1;
    e.page_priv = 1'b1;
    ev('0, 0);
    rdc(st, 32'h00ff_0431);
    wr(st, 32'hffff_ffff);
    rdc(st, 32'h3fff_8fff);
    for (int k = 0; k < 9; k++) begin
      clr();
      e = mk(evt_kind_t'(k), 8'h80, 32'h0);
      e.invalid_len = (k == 1) || (k == 6);
      e.bad_va = 1'b1;
      ev('0, k % 2);
      apb(1'b0, st, 32'h0);
      chk(rd & 32'h0000_bf81, (k == 0) ? 32'h8000 : 32'h1);
    end
    test_done();
  end
endmodule // data_mmu_fault_status_bench
